//--- src/rtcc_pkg.sv
// Constants for the real-time clock control and status block.
// Assumes a 100 MHz reference clock and byte-wide register accesses.
package rtcc_pkg;

  // Register port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Register offsets and alarm register windows
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 7'h0F;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h10;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_A_FIRST = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_A_LAST = 7'h0A;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_B_FIRST = 7'h0B;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_B_LAST = 7'h0E;

  // Control register fields
  localparam int CTL_OSC_DIS_BIT = 7;
  localparam int CTL_SENSE_DIS_BIT = 5;
  localparam int CTL_GLITCH_BIT = 4;
  localparam int CTL_SQW_BIT = 3;
  localparam int CTL_ROUTE_BIT = 2;
  localparam int CTL_B_IE_BIT = 1;
  localparam int CTL_A_IE_BIT = 0;

  // Status register fields
  localparam int ST_OSF_BIT = 7;
  localparam int ST_FLAG_B_BIT = 1;
  localparam int ST_FLAG_A_BIT = 0;

  // Reset values
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h80;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h80;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Alarm register layout: four byte fields, bit 7 of each is a mask
  localparam int ALARM_FIELDS = 4;
  localparam int ALARM_FIELD_W = 8;
  localparam int ALARM_MASK_BIT = 7;
  localparam int ALARM_W = ALARM_FIELDS * ALARM_FIELD_W;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int GLITCH_NS = 5000;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CW = 10;
  localparam logic [GLITCH_CW-1:0] GLITCH_ZERO = 10'h000;
  localparam logic [GLITCH_CW-1:0] GLITCH_ONE = 10'h001;

  // Whole state of the block
  typedef struct packed {
    logic osc_dis;
    logic sense_dis;
    logic glitch_en;
    logic sqw_en;
    logic route;
    logic b_ie;
    logic a_ie;
    logic osc_stopped_flag;
    logic flag_b;
    logic flag_a;
    logic run_prev;
    logic filt;
    logic [GLITCH_CW-1:0] gcnt;
    logic osc_en;
    logic irq_a_n;
    logic irq_b_n;
    logic [DATA_W-1:0] rdata;
  } rtcc_state_t;

endpackage

//--- src/rtcc_ctrl_status.sv
// Control and status logic of a real-time clock: oscillator control, stop
// flag, glitch filter, square wave, alarm flags and the two interrupt pins.
// Assumes the serial engine presents byte accesses and pointer loads as
// one-cycle strobes synchronous to ref_clk, and that time_update pulses once
// per new timekeeping value.
`timescale 1ns/1ns

module rtcc_ctrl_status
  import rtcc_pkg::*;
#(
  parameter int GLITCH_CYCLES = GLITCH_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic on_backup,
  input wire logic osc_running,
  input wire logic osc_raw,
  input wire logic time_update,
  input wire logic [ALARM_W-1:0] time_now,
  input wire logic [ALARM_W-1:0] alarm_a_cfg,
  input wire logic [ALARM_W-1:0] alarm_b_cfg,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic ptr_set,
  input wire logic [ADDR_W-1:0] ptr_addr,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq_out_a_n,
  output logic irq_out_b_n,
  output logic osc_enable,
  output logic osc_filtered
);

  // Last count value of the filter before the output follows the input
  localparam logic [GLITCH_CW-1:0] GLITCH_LAST = GLITCH_CW'(GLITCH_CYCLES - 1);

  rtcc_state_t q;
  rtcc_state_t d;
  logic ctl_wr;
  logic st_wr;
  logic run_now;
  logic stop_edge;
  logic match_a;
  logic match_b;
  logic ptr_in_a;
  logic ptr_in_b;

  // Each field matches when masked or when its low seven bits agree
  function automatic logic alarm_match(input logic [ALARM_W-1:0] t, input logic [ALARM_W-1:0] a);
    logic hit;
    logic [ALARM_FIELD_W-1:0] tf;
    logic [ALARM_FIELD_W-1:0] af;
    hit = 1'b1;
    for (int i = 0; i < ALARM_FIELDS; i++) begin
      tf = t[i*ALARM_FIELD_W +: ALARM_FIELD_W];
      af = a[i*ALARM_FIELD_W +: ALARM_FIELD_W];
      if (!af[ALARM_MASK_BIT] && (tf[ALARM_MASK_BIT-1:0] != af[ALARM_MASK_BIT-1:0])) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction

  // Inclusive address window test, used for both alarm register sets
  function automatic logic in_window(input logic [ADDR_W-1:0] p, input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // Request decode
  // masked match
  assign match_a = time_update && alarm_match(time_now, alarm_a_cfg);
  assign match_b = time_update && alarm_match(time_now, alarm_b_cfg);
  assign ptr_in_a = ptr_set && in_window(ptr_addr, ADDR_ALARM_A_FIRST, ADDR_ALARM_A_LAST);
  assign ptr_in_b = ptr_set && in_window(ptr_addr, ADDR_ALARM_B_FIRST, ADDR_ALARM_B_LAST);
  assign ctl_wr = reg_wr && (reg_addr == ADDR_CONTROL);
  assign st_wr = reg_wr && (reg_addr == ADDR_STATUS);

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    run_now = 1'b0;
    stop_edge = 1'b0;
    if (ctl_wr) begin
      d.osc_dis = reg_wdata[CTL_OSC_DIS_BIT];
      d.sense_dis = reg_wdata[CTL_SENSE_DIS_BIT];
      d.glitch_en = reg_wdata[CTL_GLITCH_BIT];
      d.sqw_en = reg_wdata[CTL_SQW_BIT];
      d.route = reg_wdata[CTL_ROUTE_BIT];
      d.b_ie = reg_wdata[CTL_B_IE_BIT];
      d.a_ie = reg_wdata[CTL_A_IE_BIT];
    end
    d.osc_en = !(on_backup && d.osc_dis);
    // own stop counts as a stop, since sensing sees the gated oscillator
    run_now = osc_running && d.osc_en;
    d.run_prev = run_now;
    stop_edge = q.run_prev && !run_now;
    // clear by written 0 or by sensing disabled; the edge wins over the written 0
    if (st_wr && !reg_wdata[ST_OSF_BIT]) begin
      d.osc_stopped_flag = 1'b0;
    end
    if (stop_edge) begin
      d.osc_stopped_flag = 1'b1;
    end
    // sensing disabled holds the flag at 0
    if (d.sense_dis) begin
      d.osc_stopped_flag = 1'b0;
    end
    if (ptr_in_a) begin
      d.flag_a = 1'b0;
    end
    if (ptr_in_b) begin
      d.flag_b = 1'b0;
    end
    // written 0 clears, written 1 keeps
    if (st_wr && !reg_wdata[ST_FLAG_A_BIT]) begin
      d.flag_a = 1'b0;
    end
    if (st_wr && !reg_wdata[ST_FLAG_B_BIT]) begin
      d.flag_b = 1'b0;
    end
    // match sets flag A, set wins over clear
    if (match_a) begin
      d.flag_a = 1'b1;
    end
    // match sets flag B, set wins over clear
    if (match_b) begin
      d.flag_b = 1'b1;
    end
    // glitch filter: input must differ for the full window to pass
    if (!d.glitch_en) begin
      d.filt = osc_raw;
      d.gcnt = GLITCH_ZERO;
    end else if (osc_raw == q.filt) begin
      d.gcnt = GLITCH_ZERO;
    end else if (q.gcnt >= GLITCH_LAST) begin
      d.filt = osc_raw;
      d.gcnt = GLITCH_ZERO;
    end else begin
      d.gcnt = q.gcnt + GLITCH_ONE;
    end
    // flag A and enable on pin A
    // routing 0 merges alarm B onto pin A
    // pins follow the new flag and enable values
    d.irq_a_n = !((d.flag_a && d.a_ie) || (!d.route && d.flag_b && d.b_ie));
    // routing 1 gives alarm B its own pin while the square wave is off
    if (d.sqw_en) begin
      d.irq_b_n = d.filt;
    end else begin
      d.irq_b_n = !(d.route && d.flag_b && d.b_ie);
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_CONTROL) begin
        d.rdata = DATA_ZERO;
        d.rdata[CTL_OSC_DIS_BIT] = q.osc_dis;
        d.rdata[CTL_SENSE_DIS_BIT] = q.sense_dis;
        d.rdata[CTL_GLITCH_BIT] = q.glitch_en;
        d.rdata[CTL_SQW_BIT] = q.sqw_en;
        d.rdata[CTL_ROUTE_BIT] = q.route;
        d.rdata[CTL_B_IE_BIT] = q.b_ie;
        d.rdata[CTL_A_IE_BIT] = q.a_ie;
      end else if (reg_addr == ADDR_STATUS) begin
        d.rdata = DATA_ZERO;
        d.rdata[ST_OSF_BIT] = q.osc_stopped_flag;
        d.rdata[ST_FLAG_B_BIT] = q.flag_b;
        d.rdata[ST_FLAG_A_BIT] = q.flag_a;
      end else begin
        d.rdata = DATA_ZERO;
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q.osc_dis <= CONTROL_RESET[CTL_OSC_DIS_BIT];
      q.sense_dis <= CONTROL_RESET[CTL_SENSE_DIS_BIT];
      q.glitch_en <= CONTROL_RESET[CTL_GLITCH_BIT];
      q.sqw_en <= CONTROL_RESET[CTL_SQW_BIT];
      q.route <= CONTROL_RESET[CTL_ROUTE_BIT];
      q.b_ie <= CONTROL_RESET[CTL_B_IE_BIT];
      q.a_ie <= CONTROL_RESET[CTL_A_IE_BIT];
      q.osc_stopped_flag <= STATUS_RESET[ST_OSF_BIT];
      q.flag_b <= STATUS_RESET[ST_FLAG_B_BIT];
      q.flag_a <= STATUS_RESET[ST_FLAG_A_BIT];
      q.run_prev <= 1'b0;
      q.filt <= 1'b0;
      q.gcnt <= GLITCH_ZERO;
      q.osc_en <= 1'b1;
      q.irq_a_n <= 1'b1;
      q.irq_b_n <= 1'b1;
      q.rdata <= DATA_ZERO;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign irq_out_a_n = q.irq_a_n;
  assign irq_out_b_n = q.irq_b_n;
  assign osc_enable = q.osc_en;
  assign osc_filtered = q.filt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_edge;
    clk_en && q.run_prev && !(osc_running && d.osc_en) && !d.sense_dis;
  endsequence

  sequence s_flag_a_on;
    q.flag_a && q.a_ie;
  endsequence

  property p_osc_backup_stop;
    clk_en && on_backup && q.osc_dis && !ctl_wr |=> !osc_enable;
  endproperty
  a_osc_backup_stop: assert property (p_osc_backup_stop) else $error("oscillator not stopped on backup");

  property p_sense_dis_zero;
    q.sense_dis |-> !q.osc_stopped_flag;
  endproperty
  a_sense_dis_zero: assert property (p_sense_dis_zero) else $error("stop flag set while sensing off");

  property p_bypass;
    clk_en && !q.glitch_en && !ctl_wr |=> osc_filtered == $past(osc_raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed");

  property p_route_b;
    !q.sqw_en && q.route && q.flag_b && q.b_ie |-> !irq_out_b_n && (irq_out_a_n == !(q.flag_a && q.a_ie));
  endproperty
  a_route_b: assert property (p_route_b) else $error("alarm B not on its own pin");

  property p_pin_b_idle;
    !q.sqw_en && !q.route |-> irq_out_b_n;
  endproperty
  a_pin_b_idle: assert property (p_pin_b_idle) else $error("pin B active with routing 0");

  property p_flag_b_set;
    clk_en && match_b |=> q.flag_b;
  endproperty
  a_flag_b_set: assert property (p_flag_b_set) else $error("alarm B match lost");

  property p_osf_edge;
    s_stop_edge |=> q.osc_stopped_flag;
  endproperty
  a_osf_edge: assert property (p_osf_edge) else $error("stop edge did not set flag");

  property p_osf_keep;
    clk_en && q.osc_stopped_flag && !q.sense_dis && !ctl_wr && !(st_wr && !reg_wdata[ST_OSF_BIT]) |=> q.osc_stopped_flag;
  endproperty
  a_osf_keep: assert property (p_osf_keep) else $error("stop flag lost without a clear");

  property p_pin_a;
    s_flag_a_on |-> !irq_out_a_n;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A not low for alarm A");

  property p_ptr_clear_b;
    clk_en && ptr_in_b && !match_b |=> !q.flag_b;
  endproperty
  a_ptr_clear_b: assert property (p_ptr_clear_b) else $error("pointer did not clear flag B");

  property p_write_one_keeps;
    clk_en && st_wr && reg_wdata[ST_FLAG_A_BIT] && q.flag_a && !ptr_in_a |=> q.flag_a;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("writing 1 changed flag A");

  property p_unused_zero;
    clk_en && reg_rd && (reg_addr == ADDR_STATUS) |=> reg_rdata[ST_OSF_BIT-1:ST_FLAG_B_BIT+1] == 5'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("fixed-zero status bits read 1");

  property p_reset_osc_dis;
    $rose(rst_n) |-> q.osc_dis;
  endproperty
  a_reset_osc_dis: assert property (p_reset_osc_dis) else $error("oscillator disable not set by reset");

  property p_reset_ctl_clear;
    $rose(rst_n) |-> !(q.sense_dis || q.glitch_en || q.sqw_en || q.route || q.b_ie || q.a_ie);
  endproperty
  a_reset_ctl_clear: assert property (p_reset_ctl_clear) else $error("control bits not cleared by reset");

  property p_reset_osf;
    $rose(rst_n) |-> q.osc_stopped_flag;
  endproperty
  a_reset_osf: assert property (p_reset_osf) else $error("stop flag not set by reset");

  property p_sqw_pin;
    q.sqw_en |-> irq_out_b_n == osc_filtered;
  endproperty
  a_sqw_pin: assert property (p_sqw_pin) else $error("square wave missing on pin B");

  property p_flag_a_set;
    clk_en && match_a |=> q.flag_a;
  endproperty
  a_flag_a_set: assert property (p_flag_a_set) else $error("alarm A match lost");

  property p_ptr_clear_a;
    clk_en && ptr_in_a && !match_a |=> !q.flag_a;
  endproperty
  a_ptr_clear_a: assert property (p_ptr_clear_a) else $error("pointer did not clear flag A");

  sequence s_flag_b_merged;
    !q.route && q.flag_b && q.b_ie;
  endsequence

  property p_pin_a_merged;
    s_flag_b_merged |-> !irq_out_a_n;
  endproperty
  a_pin_a_merged: assert property (p_pin_a_merged) else $error("alarm B not merged onto pin A");

endmodule

//--- tb/rtcc_host_model.sv
// Host model: the serial engine's view of register strobes and pointer loads.
// Assumes the caller runs on falling edges of ref_clk; one access per call.
`timescale 1ns/1ns

module rtcc_host_model
  import rtcc_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [DATA_W-1:0] reg_wdata,
  output logic ptr_set,
  output logic [ADDR_W-1:0] ptr_addr
);

  // Idle values before the first access
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    ptr_set = 1'b0;
    ptr_addr = 7'h00;
  end

  // One-cycle strobe; strobes drop to 0 and address and data are inverted so stale values never look valid
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Pointer load pulse, as at the start of a serial transaction
  task automatic ptr(input logic [ADDR_W-1:0] a);
    @(negedge ref_clk);
    ptr_addr = a;
    ptr_set = 1'b1;
    @(negedge ref_clk);
    ptr_set = 1'b0;
    ptr_addr = ~a;
  endtask

endmodule

//--- tb/testbench.sv
// Self-checking bench for the clock control and status block.
// Assumes the host model drives register traffic; a short glitch count is used.
`timescale 1ns/1ns

module testbench
  import rtcc_pkg::*;
;
  typedef struct packed {logic [7:0] ctl; logic a_n; logic b_n;} rtcc_row_t;
  logic ref_clk, rst_n, clk_en, on_backup, osc_running, osc_raw, time_update;
  logic [ALARM_W-1:0] time_now, alarm_a_cfg, alarm_b_cfg;
  logic [ADDR_W-1:0] reg_addr, ptr_addr;
  logic reg_wr, reg_rd, ptr_set, irq_out_a_n, irq_out_b_n, osc_enable, osc_filtered;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  int checks = 0;
  int fail_count = 0;
  rtcc_row_t rows[6];

  rtcc_ctrl_status #(.GLITCH_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .on_backup(on_backup), .osc_running(osc_running), .osc_raw(osc_raw), .time_update(time_update),
    .time_now(time_now), .alarm_a_cfg(alarm_a_cfg), .alarm_b_cfg(alarm_b_cfg), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .ptr_set(ptr_set), .ptr_addr(ptr_addr),
    .reg_rdata(reg_rdata), .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n),
    .osc_enable(osc_enable), .osc_filtered(osc_filtered));

  rtcc_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .ptr_set(ptr_set), .ptr_addr(ptr_addr));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_host.acc(1'b1, a, d);
  endtask

  // Read data is registered, so it is settled by the falling edge after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_host.acc(1'b0, a, DATA_ZERO);
    chk(reg_rdata, e);
  endtask

  task automatic tick();
    @(negedge ref_clk);
    time_update = 1'b1;
    @(negedge ref_clk);
    time_update = 1'b0;
  endtask

  function automatic logic [DATA_W-1:0] pins();
    return {6'h00, irq_out_a_n, irq_out_b_n};
  endfunction

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    on_backup = 1'b0;
    osc_running = 1'b1;
    osc_raw = 1'b0;
    time_update = 1'b0;
    time_now = 32'h00000000;
    alarm_a_cfg = 32'h80808080;
    alarm_b_cfg = 32'h80808080;
    rows = '{'{8'h00, 1'b1, 1'b1}, '{8'h01, 1'b0, 1'b1}, '{8'h02, 1'b0, 1'b1},
             '{8'h06, 1'b1, 1'b0}, '{8'h05, 1'b0, 1'b1}, '{8'h07, 1'b0, 1'b0}};
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_STATUS, STATUS_RESET);
    chk({7'h00, osc_enable}, 8'h01);
    chk(pins(), 8'h03);
    rd(7'h05, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h80);
    // Routing table: every alarm field masked, so each update matches both alarms
    foreach (rows[i]) begin
      wr(ADDR_CONTROL, rows[i].ctl | 8'h40);
      wr(ADDR_STATUS, 8'h00);
      tick();
      rd(ADDR_CONTROL, rows[i].ctl);
      rd(ADDR_STATUS, 8'h03);
      chk(pins(), {6'h00, rows[i].a_n, rows[i].b_n});
    end
    // Pointer loads clear only their own flag; other windows are ignored
    i_host.ptr(ADDR_ALARM_B_LAST);
    rd(ADDR_STATUS, 8'h01);
    chk(pins(), 8'h01);
    i_host.ptr(7'h11);
    rd(ADDR_STATUS, 8'h01);
    i_host.ptr(ADDR_ALARM_A_FIRST);
    rd(ADDR_STATUS, 8'h00);
    chk(pins(), 8'h03);
    tick();
    wr(ADDR_CONTROL, 8'h04);
    chk(pins(), 8'h03);
    rd(ADDR_STATUS, 8'h03);
    // Frozen clock enable drops the write
    clk_en = 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    clk_en = 1'b1;
    rd(ADDR_CONTROL, 8'h04);
    // Seconds-only match on alarm A; bit 7 of the time value is ignored
    alarm_a_cfg = 32'h80808005;
    wr(ADDR_STATUS, 8'h00);
    time_now = 32'h00000006;
    tick();
    rd(ADDR_STATUS, 8'h02);
    time_now = 32'h00000085;
    tick();
    rd(ADDR_STATUS, 8'h03);
    // Backup supply with the disable bit stops the oscillator; the stop is flagged unless sensing is disabled
    wr(ADDR_STATUS, 8'h00);
    on_backup = 1'b1;
    chk({7'h00, osc_enable}, 8'h01);
    wr(ADDR_CONTROL, 8'h80);
    chk({7'h00, osc_enable}, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_CONTROL, 8'hA0);
    chk({7'h00, osc_enable}, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    // Sensed oscillator stop while on main supply
    on_backup = 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    osc_running = 1'b0;
    @(negedge ref_clk);
    osc_running = 1'b1;
    rd(ADDR_STATUS, 8'h80);
    // Glitch filter: a two-cycle pulse is dropped, a long level passes
    wr(ADDR_CONTROL, 8'h10);
    osc_raw = 1'b1;
    repeat (2) @(negedge ref_clk);
    osc_raw = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, osc_filtered}, 8'h00);
    osc_raw = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, osc_filtered}, 8'h01);
    // Filter bypassed, square wave on pin B
    wr(ADDR_CONTROL, 8'h08);
    osc_raw = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({6'h00, osc_filtered, irq_out_b_n}, 8'h00);
    osc_raw = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({6'h00, osc_filtered, irq_out_b_n}, 8'h03);
    // Stop edge and a 0 write to the stop flag in one cycle: the edge wins
    fork
      wr(ADDR_STATUS, 8'h00);
      begin
        @(negedge ref_clk);
        osc_running = 1'b0;
        @(negedge ref_clk);
        osc_running = 1'b1;
      end
    join
    rd(ADDR_STATUS, 8'h80);
    // Match and pointer clear in one cycle: the match wins
    fork
      tick();
      i_host.ptr(ADDR_ALARM_A_LAST);
    join
    rd(ADDR_STATUS, 8'h83);
    // Window end points on their own
    i_host.ptr(ADDR_ALARM_A_LAST);
    rd(ADDR_STATUS, 8'h82);
    i_host.ptr(ADDR_ALARM_B_FIRST);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h00);
    // Second reset in mid-run: outputs and registers return to reset values
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk({4'h0, osc_enable, osc_filtered, irq_out_a_n, irq_out_b_n}, 8'h0B);
    chk(reg_rdata, DATA_ZERO);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_STATUS, STATUS_RESET);
    report_and_stop();
  end

endmodule
